// >>> inc/ckr_pkg.sv
/*
 * Constants and types for the clock select and reset flag block.
 * Assumes 8-bit register file addressing and a 25 MHz block clock.
 */
package ckr_pkg;

    localparam logic [7:0] CLOCK_FLAGS_ADDR       = 8'hF2;
    localparam logic [7:0] PLL_CONFIGURATION_ADDR = 8'hF6;

    // Field positions in clock_flags
    localparam int STOP_FLAG_BIT  = 7;
    localparam int WDG_FLAG_BIT   = 6;
    localparam int SOFT_FLAG_BIT  = 5;
    localparam int OSC_STOP_BIT   = 4;
    localparam int DIV16_BIT      = 3;
    localparam int ALT_STATUS_BIT = 2;
    localparam int PLL_LOCK_BIT   = 1;
    localparam int PLL_SEL_BIT    = 0;

    // Field positions in pll_configuration
    localparam int MULT_LSB = 4;
    localparam int MULT_MSB = 5;
    localparam int DIV_LSB  = 0;
    localparam int DIV_MSB  = 2;

    localparam logic [7:0] CLOCK_FLAGS_RESET = 8'h08;
    localparam logic [1:0] MULT_RESET        = 2'h0;
    localparam logic [2:0] DIV_PLL_OFF       = 3'h7;
    localparam logic [7:0] READ_ZERO         = 8'h00;

    // Multiplier codes and factors
    localparam logic [1:0] MULT_CODE_X14 = 2'h2;
    localparam logic [1:0] MULT_CODE_X10 = 2'h0;
    localparam logic [1:0] MULT_CODE_X8  = 2'h3;
    localparam logic [3:0] FACTOR_14     = 4'hE;
    localparam logic [3:0] FACTOR_10     = 4'hA;
    localparam logic [3:0] FACTOR_8      = 4'h8;
    localparam logic [3:0] FACTOR_6      = 4'h6;
    localparam logic [2:0] DIV_STEP      = 3'h1;

    // Timing
    localparam int CLK_PERIOD_NS       = 40;
    localparam int SWITCH_GUARD_NS     = 80;
    localparam int SWITCH_GUARD_CYCLES =
        (SWITCH_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] GUARD_LOAD  = 3'(SWITCH_GUARD_CYCLES);
    localparam logic [2:0] GUARD_DONE  = 3'h0;
    localparam logic [2:0] GUARD_STEP  = 3'h1;

    localparam int SYNC_WIDTH  = 2;
    localparam int SRC_COUNT   = 4;

    typedef enum logic [1:0] {
        SRC_MAIN       = 2'b00,
        SRC_MAIN_DIV16 = 2'b01,
        SRC_PLL        = 2'b10,
        SRC_ALT        = 2'b11
    } ckr_src_t;

    typedef enum logic [1:0] {
        SW_RUN  = 2'b00,
        SW_DROP = 2'b01
    } ckr_sw_state_t;

endpackage

// >>> design/ckr_sync.sv
/*
 * Two-flop synchroniser for the asynchronous status inputs.
 * Assumes inputs are levels that stay stable for several clocks.
 */
`timescale 1ns/10ps
module ckr_sync
    import ckr_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    input  wire logic [SYNC_WIDTH-1:0] async_in,
    output logic      [SYNC_WIDTH-1:0] sync_out
);

    logic [SYNC_WIDTH-1:0] meta_ff;
    logic [SYNC_WIDTH-1:0] sync_ff;

    genvar i;
    generate
        for (i = 0; i < SYNC_WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                end else if (clk_en) begin
                    meta_ff[i] <= async_in[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_ff;

endmodule

// >>> design/ckr_clk_switch.sv
/*
 * Break-before-make selector for the system clock gates.
 * Assumes the gate enables drive latch-based clock gates downstream.
 */
`timescale 1ns/10ps
module ckr_clk_switch
    import ckr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    input  wire ckr_src_t             src_req,
    output ckr_src_t                  src_cur,
    output logic      [SRC_COUNT-1:0] gate_en,
    output logic                      switching
);

    ckr_sw_state_t             state_ff;
    ckr_sw_state_t             nxt_state;
    ckr_src_t                  cur_ff;
    ckr_src_t                  nxt_cur;
    logic          [2:0]       guard_ff;
    logic          [2:0]       nxt_guard;
    logic          [SRC_COUNT-1:0] gate_ff;

    // All gates closed for the guard time, so no runt pulse escapes
    always_comb begin
        nxt_state = state_ff;
        nxt_cur   = cur_ff;
        nxt_guard = guard_ff;
        case (state_ff)
            SW_RUN: begin
                if (src_req != cur_ff) begin
                    nxt_state = SW_DROP;
                    nxt_guard = GUARD_LOAD;
                end
            end
            SW_DROP: begin
                if (guard_ff == GUARD_DONE) begin
                    nxt_state = SW_RUN;
                    nxt_cur   = src_req;
                end else begin
                    nxt_guard = guard_ff - GUARD_STEP;
                end
            end
            default: begin
                nxt_state = SW_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= SW_RUN;
            cur_ff   <= SRC_MAIN;
            guard_ff <= GUARD_DONE;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            cur_ff   <= nxt_cur;
            guard_ff <= nxt_guard;
        end
    end

    genvar i;
    generate
        for (i = 0; i < SRC_COUNT; i++) begin : g_gate
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    gate_ff[i] <= (i == int'(SRC_MAIN));
                end else if (clk_en) begin
                    gate_ff[i] <= (nxt_state == SW_RUN) &&
                                  (int'(nxt_cur) == i);
                end
            end
        end
    endgenerate

    assign src_cur   = cur_ff;
    assign gate_en   = gate_ff;
    assign switching = (state_ff == SW_DROP);

endmodule

// >>> design/ckr_clock_reset.sv
/*
 * Clock source selection, PLL configuration and reset cause flags.
 * Assumes rst is the pin/power-on reset, register file strobes and
 * core events are on clk, the alternate clock and PLL lock are async.
 */
`timescale 1ns/10ps
// Contract
// - Stop flag set by hardware on stop, cleared only by software; here an internal reset also clears it.
// - Watchdog flag read-only, set by watchdog reset; register reads 48h.
// - Software flag read-only, set by HALT reset; register reads 28h.
// - Pin or power-on reset clears both cause flags; reads 08h.
// - Oscillator stops when stop enable set and alternate clock active.
// - Writing 1 to stop enable pends, reads 0 until alternate runs.
// - Writing 0 to stop enable cancels any pending request.
// - Div16 bit 0 gives main/16 and PLL off; toggles raise interrupt.
// - Alternate status set only when alternate clock present and chosen.
// - Lock bit reads PLL locked; unlocked PLL cannot be selected.
// - PLL select cleared: divider 111, crystal stop, low-power WFI, div16 0.
// - PLL select 0 picks main clock, 1 picks PLL output.
// - Alternate clock beats everything; div16 clear beats PLL select.
// - Multiplier codes 10,00,11,01 give 14,10,8,6.
// - Divider code n divides by n+1; 111 is PLL off and reset.
// - Reset on pin, enabled HALT, or watchdog end of count.
// - Pin reset overrides all, loads reset values, weak pull-ups on pins.
// - Reset acts asynchronously the moment the pin goes low; here rst is active high.
// - Watchdog timeout resets device without driving the reset pin.
// - With watchdog enabled, HALT leaves the oscillator running.
// - HALT stop holds oscillator clock high until an external reset.
// - Alternate select request only takes effect with clock on its pin.
// - Leaving stop raises interrupt and sets stop flag.
module ckr_clock_reset
    import ckr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       halt_exec,
    input  wire logic       wfi_exec,
    input  wire logic       wfi_active,
    input  wire logic       low_power_wfi_enable,
    input  wire logic       wfi_clock_select,
    input  wire logic       alternate_clock_select,
    input  wire logic       software_reset_enable,
    input  wire logic       watchdog_mode_enable,
    input  wire logic       watchdog_timeout,
    input  wire logic       stop_exit,
    input  wire logic       alternate_clock_pin_active,
    input  wire logic       pll_lock_raw,
    output logic            internal_reset,
    output logic            io_weak_pullup,
    output logic            oscillator_enable,
    output logic            oscillator_clock_hold_high,
    output logic            pll_enable,
    output logic      [1:0] pll_multiplier_field,
    output logic      [2:0] pll_divider_field,
    output logic      [3:0] pll_multiply_by,
    output logic      [2:0] pll_divide_by,
    output ckr_src_t        sys_clk_source,
    output logic      [3:0] sys_clk_gate,
    output logic            clock_switching,
    output logic            clock_irq
);

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] target);
        hit = (a == target);
    endfunction

    function automatic logic [3:0] mult_factor(input logic [1:0] code);
        case (code)
            MULT_CODE_X14: mult_factor = FACTOR_14;
            MULT_CODE_X10: mult_factor = FACTOR_10;
            MULT_CODE_X8:  mult_factor = FACTOR_8;
            default:       mult_factor = FACTOR_6;
        endcase
    endfunction

    logic       stop_flag_ff;
    logic       wdg_flag_ff;
    logic       soft_flag_ff;
    logic       osc_stop_ff;
    logic       osc_pend_ff;
    logic       div16_ff;
    logic       pll_sel_ff;
    logic [1:0] mult_ff;
    logic [2:0] div_ff;
    logic       halted_ff;
    logic       alt_status_ff;
    logic       irq_ff;
    logic       int_reset_ff;
    logic       pullup_ff;
    logic       osc_en_ff;
    logic       pll_en_ff;
    logic [7:0] rdata_ff;

    logic [SYNC_WIDTH-1:0] async_raw;
    logic [SYNC_WIDTH-1:0] async_sync;
    ckr_src_t              src_req;

    // Both level inputs come from outside this clock domain
    assign async_raw = {pll_lock_raw, alternate_clock_pin_active};

    ckr_sync u_sync (
        .clk      (clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in (async_raw),
        .sync_out (async_sync)
    );

    wire alt_present = async_sync[0];
    wire pll_lock_s  = async_sync[1];

    // Register file decode
    wire wr_flags = reg_wr & hit(reg_addr, CLOCK_FLAGS_ADDR);
    wire wr_pllc  = reg_wr & hit(reg_addr, PLL_CONFIGURATION_ADDR);
    wire rd_flags = hit(reg_addr, CLOCK_FLAGS_ADDR);
    wire rd_pllc  = hit(reg_addr, PLL_CONFIGURATION_ADDR);

    // Reset sources; watchdog wins if both fire together
    wire wdg_reset  = watchdog_mode_enable & watchdog_timeout;
    wire soft_reset = halt_exec & software_reset_enable &
                      ~wdg_reset;
    wire int_reset  = wdg_reset | soft_reset;
    // Watchdog keeps the oscillator alive so a stray HALT cannot kill it
    wire halt_stop  = halt_exec & ~software_reset_enable &
                      ~watchdog_mode_enable;

    // Alternate clock request and status
    wire lp_wfi      = wfi_active & low_power_wfi_enable;
    wire alt_request = alternate_clock_select |
                       (lp_wfi & wfi_clock_select);
    wire nxt_alt_status = alt_request & alt_present;

    // Crystal runs unless halted or, with stop enable set, replaced by a live alternate clock
    wire osc_run = ~halted_ff &
                   ~(osc_stop_ff & alt_status_ff);

    // Oscillator stop enable: pending until alternate is running
    wire promote = osc_pend_ff & alt_status_ff;
    wire nxt_osc_pend = int_reset ? 1'b0 :
                        wr_flags  ? reg_wdata[OSC_STOP_BIT] :
                        promote   ? 1'b0 : osc_pend_ff;
    wire nxt_osc_stop = int_reset ? 1'b0 :
        (wr_flags & ~reg_wdata[OSC_STOP_BIT]) ? 1'b0 :
        promote ? 1'b1 : osc_stop_ff;

    // Divide-by-16 select
    wire div16_toggle = wr_flags &
                        (reg_wdata[DIV16_BIT] != div16_ff);
    wire nxt_div16 = int_reset ? CLOCK_FLAGS_RESET[DIV16_BIT] :
                     wr_flags  ? reg_wdata[DIV16_BIT] : div16_ff;
    // Low-power WFI forces the slow clock, the bit is left alone
    wire eff_div16 = ~div16_ff | lp_wfi;

    // PLL runs only with div16 clear of force, divider not 111
    wire pll_on = div16_ff & (div_ff != DIV_PLL_OFF) &
                  ~lp_wfi & osc_run;
    wire pll_locked = pll_lock_s & pll_on;

    // Drop the PLL first so an unlocked PLL never clocks the core
    wire pll_sel_clear = int_reset |
        (wr_pllc & (reg_wdata[DIV_MSB:DIV_LSB] == DIV_PLL_OFF)) |
        ~osc_run |
        (wfi_exec & low_power_wfi_enable) |
        (wr_flags & ~reg_wdata[DIV16_BIT]);
    // Setting is refused while the PLL is not locked
    wire nxt_pll_sel = pll_sel_clear ? 1'b0 :
        wr_flags ? (reg_wdata[PLL_SEL_BIT] & pll_locked) :
        pll_sel_ff;
    wire use_pll = pll_sel_ff & pll_locked;

    // Alternate beats div16, div16 beats PLL select
    assign src_req = alt_status_ff ? SRC_ALT :
                     eff_div16     ? SRC_MAIN_DIV16 :
                     use_pll       ? SRC_PLL : SRC_MAIN;

    // Set wins over a software clear in the same cycle
    wire nxt_stop_flag = stop_exit |
        (stop_flag_ff & ~(wr_flags & ~reg_wdata[STOP_FLAG_BIT]));

    wire nxt_irq = div16_toggle | stop_exit |
                   (nxt_alt_status != alt_status_ff);

    wire [7:0] flags_view = {stop_flag_ff, wdg_flag_ff, soft_flag_ff,
                             osc_stop_ff, div16_ff, alt_status_ff,
                             pll_locked, pll_sel_ff};
    wire [7:0] pllc_view  = {2'h0, mult_ff, 1'h0, div_ff};
    wire [7:0] nxt_rdata  = rd_flags ? flags_view :
                            rd_pllc  ? pllc_view : READ_ZERO;

    // Each internal reset reloads both cause flags with its own cause; the pin clears them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdg_flag_ff  <= CLOCK_FLAGS_RESET[WDG_FLAG_BIT];
            soft_flag_ff <= CLOCK_FLAGS_RESET[SOFT_FLAG_BIT];
            halted_ff    <= 1'b0;
        end else if (clk_en) begin
            if (int_reset) begin
                wdg_flag_ff  <= wdg_reset;
                soft_flag_ff <= soft_reset;
            end
            // Only the pin reset wakes a halted crystal
            if (halt_stop) begin
                halted_ff <= 1'b1;
            end
        end
    end

    // Pin reset overrides every other source
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_flag_ff <= CLOCK_FLAGS_RESET[STOP_FLAG_BIT];
            osc_stop_ff  <= CLOCK_FLAGS_RESET[OSC_STOP_BIT];
            osc_pend_ff  <= 1'b0;
            div16_ff     <= CLOCK_FLAGS_RESET[DIV16_BIT];
            pll_sel_ff   <= CLOCK_FLAGS_RESET[PLL_SEL_BIT];
            alt_status_ff <= CLOCK_FLAGS_RESET[ALT_STATUS_BIT];
        end else if (clk_en) begin
            stop_flag_ff <= int_reset ? 1'b0 : nxt_stop_flag;
            osc_stop_ff  <= nxt_osc_stop;
            osc_pend_ff  <= nxt_osc_pend;
            div16_ff     <= nxt_div16;
            pll_sel_ff   <= nxt_pll_sel;
            alt_status_ff <= nxt_alt_status;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mult_ff <= MULT_RESET;
            div_ff  <= DIV_PLL_OFF;
        end else if (clk_en) begin
            if (int_reset) begin
                mult_ff <= MULT_RESET;
                div_ff  <= DIV_PLL_OFF;
            end else if (wr_pllc) begin
                mult_ff <= reg_wdata[MULT_MSB:MULT_LSB];
                div_ff  <= reg_wdata[DIV_MSB:DIV_LSB];
            end
        end
    end

    // Internal reset is a pulse to the core; no pin is driven
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_reset_ff <= 1'b0;
            pullup_ff    <= 1'b1;
            irq_ff       <= 1'b0;
        end else if (clk_en) begin
            int_reset_ff <= int_reset;
            pullup_ff    <= int_reset;
            irq_ff       <= nxt_irq;
        end
    end

    // Read data held until the next strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_en_ff <= 1'b1;
            pll_en_ff <= 1'b0;
            rdata_ff  <= READ_ZERO;
        end else if (clk_en) begin
            osc_en_ff <= osc_run;
            pll_en_ff <= pll_on;
            if (reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    ckr_clk_switch u_switch (
        .clk       (clk),
        .rst       (rst),
        .clk_en    (clk_en),
        .src_req   (src_req),
        .src_cur   (sys_clk_source),
        .gate_en   (sys_clk_gate),
        .switching (clock_switching)
    );

    assign reg_rdata                  = rdata_ff;
    assign internal_reset             = int_reset_ff;
    assign io_weak_pullup             = pullup_ff;
    assign oscillator_enable          = osc_en_ff;
    assign oscillator_clock_hold_high = ~osc_en_ff;
    assign pll_enable                 = pll_en_ff;
    assign pll_multiplier_field       = mult_ff;
    assign pll_divider_field          = div_ff;
    assign pll_multiply_by            = mult_factor(mult_ff);
    assign pll_divide_by              = div_ff + DIV_STEP;
    assign clock_irq                  = irq_ff;

endmodule

// >>> sim/ckr_clock_reset_checker.sv
/*
 * Port-level assertions for the clock select and reset flag block.
 * Assumes it is bound to ckr_clock_reset and sees only its ports.
 */
`timescale 1ns/10ps
module ckr_clock_reset_checker
    import ckr_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       clk_en,
    input wire logic       halt_exec,
    input wire logic       software_reset_enable,
    input wire logic       watchdog_mode_enable,
    input wire logic       watchdog_timeout,
    input wire logic       stop_exit,
    input wire logic       internal_reset,
    input wire logic       io_weak_pullup,
    input wire logic       oscillator_enable,
    input wire logic       oscillator_clock_hold_high,
    input wire logic       pll_enable,
    input wire logic [1:0] pll_multiplier_field,
    input wire logic [2:0] pll_divider_field,
    input wire logic [3:0] pll_multiply_by,
    input wire logic [2:0] pll_divide_by,
    input wire ckr_src_t   sys_clk_source,
    input wire logic [3:0] sys_clk_gate,
    input wire logic       clock_switching,
    input wire logic       clock_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_stop_irq_raise: assert property (
        clk_en && stop_exit |=> clock_irq) else $error("no irq on stop exit");
    a_wdg_reset_pulse: assert property (
        clk_en && watchdog_timeout && watchdog_mode_enable
        |=> internal_reset && io_weak_pullup) else $error("no wdg reset");
    a_halt_keeps_osc: assert property (
        clk_en && halt_exec && watchdog_mode_enable && !software_reset_enable
        && oscillator_enable |=> oscillator_enable) else $error("osc lost");
    a_halt_stops_osc: assert property (
        clk_en && halt_exec && !watchdog_mode_enable && !software_reset_enable
        |-> ##2 !oscillator_enable) else $error("halt kept osc");
    a_osc_hold_high: assert property (
        oscillator_clock_hold_high == !oscillator_enable)
        else $error("hold high wrong");
    a_mult_decode: assert property (
        pll_multiply_by == (pll_multiplier_field == 2'h2 ? 4'hE :
        pll_multiplier_field == 2'h0 ? 4'hA :
        pll_multiplier_field == 2'h3 ? 4'h8 : 4'h6)) else $error("bad mult");
    a_div_value: assert property (
        pll_divider_field != 3'h7
        |-> pll_divide_by == pll_divider_field + 3'h1)
        else $error("bad divide");
    a_pll_off_code: assert property (
        pll_divider_field == 3'h7 ##1 pll_divider_field == 3'h7
        |-> !pll_enable) else $error("pll on with 111");
    a_pll_src_on: assert property (
        $rose(sys_clk_source == SRC_PLL) |-> pll_enable)
        else $error("pll source while off");
    a_gap_gates: assert property (
        clock_switching |-> sys_clk_gate == 4'h0) else $error("gate open");
    a_gate_onehot: assert property (
        !clock_switching |-> sys_clk_gate == (4'h1 << sys_clk_source))
        else $error("gate mismatch");
    a_break_make: assert property (
        $changed(sys_clk_source) && !internal_reset |-> $past(clock_switching))
        else $error("source changed without gap");
endmodule

bind ckr_clock_reset ckr_clock_reset_checker i_chk (
    .clk, .rst, .clk_en, .halt_exec, .software_reset_enable,
    .watchdog_mode_enable, .watchdog_timeout, .stop_exit, .internal_reset,
    .io_weak_pullup, .oscillator_enable, .oscillator_clock_hold_high,
    .pll_enable, .pll_multiplier_field, .pll_divider_field,
    .pll_multiply_by, .pll_divide_by, .sys_clk_source, .sys_clk_gate,
    .clock_switching, .clock_irq);

// >>> sim/ckr_xtal_pll_model.sv
/*
 * Behavioural crystal, PLL and alternate clock source.
 * Assumes alt_run is commanded by the bench; lock time is a parameter.
 */
`timescale 1ns/10ps
module ckr_xtal_pll_model
#(
    parameter int LOCK_CYCLES = 20
)
(
    input  wire logic clk,
    input  wire logic pll_enable,
    input  wire logic oscillator_enable,
    input  wire logic alt_run,
    output logic      pll_lock_raw,
    output logic      alternate_clock_pin_active
);
    int lock_cnt_ff = 0;

    // Lock lost on the next clock edge after the PLL or crystal goes off
    always @(posedge clk) begin
        if (!(pll_enable && oscillator_enable)) lock_cnt_ff <= 0;
        else if (lock_cnt_ff < LOCK_CYCLES) lock_cnt_ff <= lock_cnt_ff + 1;
    end
    assign pll_lock_raw = (lock_cnt_ff == LOCK_CYCLES);
    assign alternate_clock_pin_active = alt_run;
endmodule

// >>> sim/ckr_clock_reset_tb.sv
/*
 * Self-checking bench for the clock select and reset flag block.
 * Assumes the bound checker and the crystal/PLL model beside it.
 */
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    fails++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
`define WAITC(c) for (int n = 0; n < 80 && !(c); n++) @(negedge clk);
module ckr_clock_reset_tb;
    import ckr_pkg::*;
    typedef struct packed {
        logic [7:0] wd;
        logic [3:0] mul;
        logic [2:0] div;
    } ckr_row_t;
    localparam ckr_row_t ROWS [6] = '{'{8'h20, 4'hE, 3'h1},
        '{8'h31, 4'h8, 3'h2}, '{8'h16, 4'h6, 3'h7}, '{8'h05, 4'hA, 3'h6},
        '{8'h23, 4'hE, 3'h4}, '{8'h07, 4'hA, 3'h0}};
    localparam logic [7:0] A_FL = CLOCK_FLAGS_ADDR;
    localparam logic [7:0] A_PC = PLL_CONFIGURATION_ADDR;
    logic clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
    logic halt_exec = 0, wfi_exec = 0, wfi_active = 0, alt_run = 0;
    logic low_power_wfi_enable = 0, wfi_clock_select = 0;
    logic alternate_clock_select = 0, software_reset_enable = 0;
    logic watchdog_mode_enable = 0, watchdog_timeout = 0, stop_exit = 0;
    logic alternate_clock_pin_active, pll_lock_raw, internal_reset;
    logic io_weak_pullup, oscillator_enable, oscillator_clock_hold_high;
    logic pll_enable, clock_switching, clock_irq;
    logic [1:0] pll_multiplier_field;
    logic [2:0] pll_divider_field, pll_divide_by;
    logic [3:0] pll_multiply_by, sys_clk_gate;
    ckr_src_t sys_clk_source;
    int fails = 0, samples_checked = 0, irq_n = 0, n0;

    always #20 clk = ~clk;
    always @(negedge clk) if (clock_irq === 1'b1) irq_n <= irq_n + 1;

    ckr_clock_reset i_dut (.clk, .rst, .clk_en, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .halt_exec, .wfi_exec, .wfi_active,
        .low_power_wfi_enable, .wfi_clock_select, .alternate_clock_select,
        .software_reset_enable, .watchdog_mode_enable, .watchdog_timeout,
        .stop_exit, .alternate_clock_pin_active, .pll_lock_raw,
        .internal_reset, .io_weak_pullup, .oscillator_enable,
        .oscillator_clock_hold_high, .pll_enable, .pll_multiplier_field,
        .pll_divider_field, .pll_multiply_by, .pll_divide_by,
        .sys_clk_source, .sys_clk_gate, .clock_switching, .clock_irq);
    ckr_xtal_pll_model i_far (.clk, .pll_enable, .oscillator_enable,
        .alt_run, .pll_lock_raw, .alternate_clock_pin_active);

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk) reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk) reg_rd = 1'b0;
        rv = reg_rdata;
        @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk) s = 1'b0;
        @(negedge clk);
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Whole run is well under a thousand cycles
    initial begin
        #(40 * 5000);
        fails++;
        conclude();
    end

    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        rd(A_FL); `CHK(rv, 8'h08)
        rd(A_PC); `CHK(rv, 8'h07)
        rd(8'h10); `CHK(rv, 8'h00)
        foreach (ROWS[i]) begin
            wr(A_PC, ROWS[i].wd);
            rd(A_PC); `CHK(rv, ROWS[i].wd)
            `CHK(pll_multiply_by, ROWS[i].mul)
            `CHK(pll_divide_by, ROWS[i].div)
        end
        wr(A_FL, 8'hEF);
        rd(A_FL); `CHK(rv, 8'h08)
        wr(A_FL, 8'h08);
        n0 = irq_n;
        pulse(stop_exit);
        `CHK(irq_n - n0, 1)
        rd(A_FL); `CHK(rv, 8'h88)
        wr(A_FL, 8'h08);
        rd(A_FL); `CHK(rv, 8'h08)
        n0 = irq_n;
        wr(A_FL, 8'h00);
        `WAITC(sys_clk_source === SRC_MAIN_DIV16 && !clock_switching)
        `CHK(sys_clk_source, SRC_MAIN_DIV16)
        `CHK(pll_enable, 1'b0)
        `CHK(irq_n - n0, 1)
        wr(A_FL, 8'h08);
        `WAITC(sys_clk_source === SRC_MAIN && !clock_switching)
        wr(A_PC, 8'h00);
        // Lock time waited before selecting the PLL
        `WAITC(pll_lock_raw === 1'b1)
        repeat (4) @(negedge clk);
        rd(A_FL); `CHK(rv, 8'h0A)
        wr(A_FL, 8'h09);
        rd(A_FL); `CHK(rv, 8'h0B)
        `WAITC(sys_clk_source === SRC_PLL && !clock_switching)
        `CHK(sys_clk_source, SRC_PLL)
        low_power_wfi_enable = 1'b1;
        wfi_active = 1'b1;
        pulse(wfi_exec);
        `WAITC(sys_clk_source === SRC_MAIN_DIV16 && !clock_switching)
        `CHK(sys_clk_source, SRC_MAIN_DIV16)
        `CHK(pll_enable, 1'b0)
        wfi_active = 1'b0;
        wr(A_PC, 8'h07);
        repeat (8) @(negedge clk);
        rd(A_FL); `CHK(rv, 8'h08)
        `CHK(sys_clk_source, SRC_MAIN)
        watchdog_mode_enable = 1'b1;
        watchdog_timeout = 1'b1;
        @(negedge clk) watchdog_timeout = 1'b0;
        `CHK(internal_reset, 1'b1)
        `CHK(io_weak_pullup, 1'b1)
        rd(A_FL); `CHK(rv, 8'h48)
        pulse(halt_exec);
        `CHK(oscillator_enable, 1'b1)
        watchdog_mode_enable = 1'b0;
        software_reset_enable = 1'b1;
        pulse(halt_exec);
        rd(A_FL); `CHK(rv, 8'h28)
        software_reset_enable = 1'b0;
        wr(A_FL, 8'h18);
        rd(A_FL); `CHK(rv, 8'h28)
        wr(A_FL, 8'h08);
        alternate_clock_select = 1'b1;
        repeat (6) @(negedge clk);
        rd(A_FL); `CHK(rv, 8'h28)
        alt_run = 1'b1;
        `WAITC(sys_clk_source === SRC_ALT && !clock_switching)
        rd(A_FL); `CHK(rv, 8'h2C)
        `CHK(oscillator_enable, 1'b1)
        `CHK(sys_clk_source, SRC_ALT)
        wr(A_FL, 8'h18);
        `WAITC(oscillator_enable === 1'b0)
        `CHK(oscillator_enable, 1'b0)
        rd(A_FL); `CHK(rv, 8'h3C)
        alternate_clock_select = 1'b0;
        alt_run = 1'b0;
        rst = 1'b1;
        #1 `CHK(io_weak_pullup, 1'b1)
        `CHK(oscillator_enable, 1'b1)
        @(negedge clk) rst = 1'b0;
        rd(A_FL); `CHK(rv, 8'h08)
        pulse(halt_exec);
        `CHK(oscillator_clock_hold_high, 1'b1)
        repeat (4) @(negedge clk);
        `CHK(oscillator_enable, 1'b0)
        // Only an outside reset pulse restarts the crystal
        rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        `CHK(oscillator_enable, 1'b1)
        conclude();
    end
endmodule
